// ---- hw/ext_bus_pkg.sv ----
package ext_bus_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned OSC_PERIOD_NS             = 10;
	localparam int unsigned MACHINE_CYCLE_NS          = 120;
	localparam int unsigned MACHINE_CYCLE_OSC         = MACHINE_CYCLE_NS / OSC_PERIOD_NS;
	localparam int unsigned RESET_HOLD_MACHINE_CYCLES = 2;
	localparam logic [4:0]  RESET_HOLD_CYCLES         = 5'(RESET_HOLD_MACHINE_CYCLES * MACHINE_CYCLE_OSC);
	localparam logic [1:0]  SETTLE_CYCLES             = 2'h3;
	localparam int unsigned CAPTURE_STAGES            = 4;

	// ****************************************
	// phases inside one machine cycle
	// ****************************************
	localparam logic [3:0] PHASE_LAST         = 4'(MACHINE_CYCLE_OSC - 1);
	localparam logic [3:0] HALF_LEN           = 4'(MACHINE_CYCLE_OSC / 2);
	localparam logic [3:0] STROBE_HIGH_LAST   = 4'h1;
	localparam logic [3:0] ADDR_LAST          = 4'h2;
	localparam logic [3:0] CODE_STROBE_FIRST  = 4'h3;
	localparam logic [3:0] CODE_STROBE_LAST   = 4'h5;
	localparam logic [3:0] DATA_STROBE_FIRST  = 4'h3;
	localparam logic [3:0] DATA_STROBE_LAST   = 4'h8;

	// ****************************************
	// register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [7:0] IDX_LOW_PORT     = 8'h80;
	localparam logic [7:0] IDX_DP_LOW       = 8'h82;
	localparam logic [7:0] IDX_DP_HIGH      = 8'h83;
	localparam logic [7:0] IDX_LATCH_CTRL   = 8'h8e;
	localparam logic [7:0] IDX_HIGH_PORT    = 8'ha0;
	localparam logic [7:0] IDX_STROBE_PORT  = 8'hb0;
	localparam logic [7:0] IDX_COMMAND      = 8'he8;
	localparam logic [7:0] IDX_STATUS       = 8'he9;
	localparam logic [7:0] IDX_FETCH_ADDR   = 8'hea;
	localparam logic [7:0] IDX_BYTE_INDEX   = 8'heb;
	localparam logic [7:0] IDX_NONE         = 8'h00;

	// ****************************************
	// reset values and fields
	// ****************************************
	localparam logic [7:0]  PORT_RESET        = 8'hff;
	localparam logic [7:0]  DP_RESET          = 8'h00;
	localparam logic [7:0]  LATCH_CTRL_RESET  = 8'h00;
	localparam logic [7:0]  BYTE_INDEX_RESET  = 8'h00;
	localparam logic [15:0] FETCH_ADDR_RESET  = 16'h0000;
	localparam int unsigned LATCH_DISABLE_BIT = 0;
	localparam int unsigned WR_STROBE_BIT     = 6;
	localparam int unsigned RD_STROBE_BIT     = 7;
	localparam int unsigned CMD_BYTE_MODE_BIT = 2;
	localparam int unsigned CMD_WDATA_LSB     = 8;

	typedef enum logic [1:0] {
		OP_NONE  = 2'h0,
		OP_READ  = 2'h1,
		OP_WRITE = 2'h2,
		OP_TABLE = 2'h3
	} op_type;

	typedef enum logic [3:0] {
		CYC_IDLE  = 4'b0001,
		CYC_FETCH = 4'b0010,
		CYC_DATA  = 4'b0100,
		CYC_TABLE = 4'b1000
	} cycle_type;

endpackage

// ---- hw/external_memory_bus_interface.sv ----
`timescale 1ns/1ps

// ****************************************
// three-stage input filter
// ****************************************
module pin_filter #(
	parameter int unsigned      WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// pin and filtered level
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;
	wire  [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);

	// a bit changes only once the last two stages agree
	always_ff @(posedge clock) begin
		if (rst) begin
			s1_reg    <= INIT;
			s2_reg    <= INIT;
			s3_reg    <= INIT;
			level_reg <= INIT;
		end else begin
			s1_reg    <= pin;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			level_reg <= (s3_reg & agree) | (level_reg & ~agree);
		end
	end
	assign level = level_reg;
endmodule

module external_memory_bus_interface
	import ext_bus_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// board straps and reset pin
	input  wire logic        reset_pin,
	input  wire logic        external_fetch_select_n,
	input  wire logic        lock_bit1_programmed,
	// low port, multiplexed address and data
	input  wire logic [7:0]  low_port_in,
	output logic      [7:0]  low_port_out,
	output logic      [7:0]  low_port_oe_n,
	// high port and strobe port
	output logic      [7:0]  high_port_out,
	output logic      [7:0]  high_port_oe_n,
	output logic      [7:0]  strobe_port_out,
	output logic      [7:0]  strobe_port_oe_n,
	// memory strobes
	output logic             address_latch_strobe_out,
	output logic             address_latch_strobe_oe_n,
	output logic             program_fetch_strobe_n
);

	// ****************************************
	// input filters and device reset
	// ****************************************
	logic       reset_level;
	logic       select_level;
	logic [7:0] low_level;
	logic [4:0] hold_count_reg;
	logic       pin_reset_reg;
	logic [1:0] settle_reg;
	logic       dev_rst;

	pin_filter #(.WIDTH(1), .INIT(1'b0)) reset_filter (
		.clock (clock),
		.rst   (rst),
		.pin   (reset_pin),
		.level (reset_level)
	);
	pin_filter #(.WIDTH(1), .INIT(1'b1)) select_filter (
		.clock (clock),
		.rst   (rst),
		.pin   (external_fetch_select_n),
		.level (select_level)
	);
	pin_filter #(.WIDTH(8), .INIT(8'hff)) low_filter (
		.clock (clock),
		.rst   (rst),
		.pin   (low_port_in),
		.level (low_level)
	);

	// reset pin must stay high for a full hold count before it takes effect
	always_ff @(posedge clock) begin
		if (rst) begin
			hold_count_reg <= '0;
			pin_reset_reg  <= 1'b0;
			settle_reg     <= '0;
		end else begin
			hold_count_reg <= !reset_level ? 5'h00 :
				(hold_count_reg == RESET_HOLD_CYCLES) ? hold_count_reg : 5'(hold_count_reg + 5'h01);
			pin_reset_reg  <= reset_level && (hold_count_reg >= 5'(RESET_HOLD_CYCLES - 5'h01));
			settle_reg     <= (settle_reg == SETTLE_CYCLES) ? settle_reg : 2'(settle_reg + 2'h1);
		end
	end
	// filters need a few cycles after rst before the strap is trusted
	assign dev_rst = rst || pin_reset_reg || (settle_reg != SETTLE_CYCLES);

	// ****************************************
	// registers and ahb-lite slave
	// ****************************************
	logic [7:0]  low_latch_reg;
	logic [7:0]  dp_low_reg;
	logic [7:0]  dp_high_reg;
	logic [7:0]  latch_ctrl_reg;
	logic [7:0]  high_latch_reg;
	logic [7:0]  strobe_latch_reg;
	logic [7:0]  byte_index_reg;
	logic [15:0] fetch_addr_reg;
	logic [7:0]  last_read_reg;
	logic [7:0]  last_code_reg;
	op_type      cmd_op_reg;
	logic        cmd_byte_mode_reg;
	logic [7:0]  cmd_wdata_reg;
	logic        cmd_pending_reg;
	logic        busy_reg;
	logic        select_latched_reg;
	logic        wr_pend_reg;
	logic        rd_wait_reg;
	logic [7:0]  idx_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rd_mux;
	logic        ext_exec;

	// address decode; anything outside the index window reads zero
	wire       take       = hsel && htrans[1] && hready;
	wire       addr_ok    = (haddr[31:10] == 22'h000000);
	wire [7:0] idx_next   = addr_ok ? haddr[9:2] : IDX_NONE;
	wire       wr_en      = wr_pend_reg && !dev_rst;
	wire       wr_cmd     = wr_en && (idx_reg == IDX_COMMAND) && !busy_reg
		&& (op_type'(hwdata[1:0]) != OP_NONE);
	wire [7:0] status_low = {6'h00, ext_exec, busy_reg};

	// bus control: writes finish in zero waits, reads take one wait state
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			idx_reg     <= IDX_NONE;
			hrdata_reg  <= '0;
		end else begin
			wr_pend_reg <= take && hwrite;
			rd_wait_reg <= take && !hwrite;
			idx_reg     <= take ? idx_next : idx_reg;
			hrdata_reg  <= rd_wait_reg ? rd_mux : hrdata_reg;
		end
	end
	assign hreadyout = !rd_wait_reg;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// read selection
	assign rd_mux =
		(idx_reg == IDX_LOW_PORT)    ? {24'h000000, low_latch_reg} :
		(idx_reg == IDX_DP_LOW)      ? {24'h000000, dp_low_reg} :
		(idx_reg == IDX_DP_HIGH)     ? {24'h000000, dp_high_reg} :
		(idx_reg == IDX_LATCH_CTRL)  ? {24'h000000, latch_ctrl_reg} :
		(idx_reg == IDX_HIGH_PORT)   ? {24'h000000, high_latch_reg} :
		(idx_reg == IDX_STROBE_PORT) ? {24'h000000, strobe_latch_reg} :
		(idx_reg == IDX_COMMAND)     ? {16'h0000, cmd_wdata_reg, 5'h00, cmd_byte_mode_reg, cmd_op_reg} :
		(idx_reg == IDX_STATUS)      ? {8'h00, last_code_reg, last_read_reg, status_low} :
		(idx_reg == IDX_FETCH_ADDR)  ? {16'h0000, fetch_addr_reg} :
		(idx_reg == IDX_BYTE_INDEX)  ? {24'h000000, byte_index_reg} : 32'h00000000;

	// ****************************************
	// code source selection
	// ****************************************
	// strap captured during device reset, used instead of the pin when locked
	always_ff @(posedge clock) begin
		if (dev_rst) begin
			select_latched_reg <= select_level;
		end
	end
	assign ext_exec = lock_bit1_programmed ? !select_latched_reg : !select_level;

	// ****************************************
	// machine cycle sequencer
	// ****************************************
	logic [3:0] phase_reg;
	cycle_type  cyc_reg;
	cycle_type  cyc_next;
	logic       code_half;
	logic       table_half;
	logic       data_cyc;
	logic [2:0] cap_pipe_reg [CAPTURE_STAGES];

	wire       half      = (phase_reg >= HALF_LEN);
	wire [3:0] hp        = half ? 4'(phase_reg - HALF_LEN) : phase_reg;
	wire       cyc_end   = (phase_reg == PHASE_LAST);
	wire       is_write  = data_cyc && (cmd_op_reg == OP_WRITE);
	wire       is_read   = data_cyc && (cmd_op_reg == OP_READ);

	// twelve phases per machine cycle, two halves of six
	always_ff @(posedge clock) begin
		if (dev_rst) begin
			phase_reg <= '0;
			cyc_reg   <= CYC_IDLE;
		end else begin
			phase_reg <= cyc_end ? 4'h0 : 4'(phase_reg + 4'h1);
			cyc_reg   <= cyc_next;
		end
	end

	// next cycle kind is chosen only on the machine cycle boundary
	always_comb begin
		cyc_next = cyc_reg;
		if (cyc_end) begin
			if (cmd_pending_reg) begin
				cyc_next = (cmd_op_reg == OP_TABLE) ? CYC_TABLE : CYC_DATA;
			end else begin
				cyc_next = ext_exec ? CYC_FETCH : CYC_IDLE;
			end
		end
	end

	// which half owns the bus and for what
	always_comb begin
		code_half  = 1'b0;
		table_half = 1'b0;
		data_cyc   = 1'b0;
		case (cyc_reg)
			CYC_IDLE: begin
				code_half = 1'b0;
			end
			// a fetch cycle, once begun, runs to its end even if the strap moves
			CYC_FETCH: begin
				code_half = 1'b1;
			end
			CYC_DATA: begin
				data_cyc = 1'b1;
			end
			CYC_TABLE: begin
				table_half = !half;
				code_half  = half && ext_exec;
			end
			default: begin
				code_half = 1'b0;
			end
		endcase
	end

	// ****************************************
	// pin drive
	// ****************************************
	wire        code_read   = code_half || table_half;
	wire        bus_owned   = code_read || data_cyc;
	wire        addr_phase  = (hp <= ADDR_LAST) && (code_read || (data_cyc && !half));
	wire        wdata_phase = is_write && (phase_reg >= DATA_STROBE_FIRST);
	wire        data_strobe = data_cyc && (phase_reg >= DATA_STROBE_FIRST) && (phase_reg <= DATA_STROBE_LAST);
	wire [15:0] ptr_addr    = {dp_high_reg, dp_low_reg};
	wire [15:0] bus_addr    = table_half ? ptr_addr :
		data_cyc ? (cmd_byte_mode_reg ? {high_latch_reg, byte_index_reg} : ptr_addr) : fetch_addr_reg;
	// one pulse skipped in the second half of a data cycle
	wire        strobe_slot = (hp <= STROBE_HIGH_LAST) && !(data_cyc && half);
	// disable bit only counts while running from on-chip code
	wire        latch_drive = ext_exec || !latch_ctrl_reg[LATCH_DISABLE_BIT]
		|| (cyc_reg == CYC_DATA) || (cyc_reg == CYC_TABLE);
	wire        fetch_low   = code_read && (hp >= CODE_STROBE_FIRST) && (hp <= CODE_STROBE_LAST);
	wire [7:0]  strobe_mask = {is_read && data_strobe, is_write && data_strobe, 6'h00};

	// all pins registered so edges follow the phase counter by one cycle
	always_ff @(posedge clock) begin
		if (dev_rst) begin
			low_port_out              <= PORT_RESET;
			low_port_oe_n             <= PORT_RESET;
			high_port_out             <= PORT_RESET;
			high_port_oe_n            <= PORT_RESET;
			strobe_port_out           <= PORT_RESET;
			strobe_port_oe_n          <= PORT_RESET;
			address_latch_strobe_out  <= 1'b0;
			address_latch_strobe_oe_n <= 1'b1;
			program_fetch_strobe_n    <= 1'b1;
		end else begin
			// address, then data, on the low port; released while reading
			low_port_out              <= addr_phase ? bus_addr[7:0] :
				wdata_phase ? cmd_wdata_reg : bus_owned ? 8'hff : low_latch_reg;
			low_port_oe_n             <= (addr_phase || wdata_phase) ? 8'h00 :
				bus_owned ? 8'hff : low_latch_reg;
			high_port_out             <= bus_owned ? bus_addr[15:8] : high_latch_reg;
			high_port_oe_n            <= bus_owned ? 8'h00 : high_latch_reg;
			strobe_port_out           <= strobe_latch_reg & ~strobe_mask;
			strobe_port_oe_n          <= strobe_latch_reg & ~strobe_mask;
			address_latch_strobe_out  <= latch_drive && strobe_slot;
			address_latch_strobe_oe_n <= !latch_drive;
			program_fetch_strobe_n    <= !fetch_low;
		end
	end

	// ****************************************
	// capture of returned bytes and register state
	// ****************************************
	// capture waits for the filtered low port to settle after the strobe
	wire [2:0] cap_in = {
		code_half && (hp == CODE_STROBE_LAST),
		table_half && (hp == CODE_STROBE_LAST),
		is_read && (phase_reg == DATA_STROBE_LAST)
	};
	wire [2:0] cap_out    = cap_pipe_reg[CAPTURE_STAGES-1];
	wire       fetch_done = cap_in[2];
	wire       op_done    = cap_out[1] || cap_out[0] || (is_write && cyc_end);

	always_ff @(posedge clock) begin
		if (dev_rst) begin
			for (int i = 0; i < CAPTURE_STAGES; i++) begin
				cap_pipe_reg[i] <= 3'h0;
			end
		end else begin
			cap_pipe_reg[0] <= cap_in;
			for (int i = 1; i < CAPTURE_STAGES; i++) begin
				cap_pipe_reg[i] <= cap_pipe_reg[i-1];
			end
		end
	end

	// software-visible registers; writes during device reset are lost
	always_ff @(posedge clock) begin
		if (dev_rst) begin
			low_latch_reg     <= PORT_RESET;
			dp_low_reg        <= DP_RESET;
			dp_high_reg       <= DP_RESET;
			latch_ctrl_reg    <= LATCH_CTRL_RESET;
			high_latch_reg    <= PORT_RESET;
			strobe_latch_reg  <= PORT_RESET;
			byte_index_reg    <= BYTE_INDEX_RESET;
			fetch_addr_reg    <= FETCH_ADDR_RESET;
			last_read_reg     <= 8'h00;
			last_code_reg     <= 8'h00;
			cmd_op_reg        <= OP_NONE;
			cmd_byte_mode_reg <= 1'b0;
			cmd_wdata_reg     <= 8'h00;
			cmd_pending_reg   <= 1'b0;
			busy_reg          <= 1'b0;
		end else begin
			if (wr_en && (idx_reg == IDX_LOW_PORT))    low_latch_reg    <= hwdata[7:0];
			if (wr_en && (idx_reg == IDX_DP_LOW))      dp_low_reg       <= hwdata[7:0];
			if (wr_en && (idx_reg == IDX_DP_HIGH))     dp_high_reg      <= hwdata[7:0];
			if (wr_en && (idx_reg == IDX_LATCH_CTRL))  latch_ctrl_reg   <= hwdata[7:0];
			if (wr_en && (idx_reg == IDX_HIGH_PORT))   high_latch_reg   <= hwdata[7:0];
			if (wr_en && (idx_reg == IDX_STROBE_PORT)) strobe_latch_reg <= hwdata[7:0];
			if (wr_en && (idx_reg == IDX_BYTE_INDEX))  byte_index_reg   <= hwdata[7:0];
			// fetch address wraps through the full 16-bit range
			if (fetch_done) begin
				fetch_addr_reg <= 16'(fetch_addr_reg + 16'h0001);
			end else if (wr_en && (idx_reg == IDX_FETCH_ADDR)) begin
				fetch_addr_reg <= hwdata[15:0];
			end
			if (cap_out[2]) last_code_reg <= low_level;
			if (cap_out[1] || cap_out[0]) last_read_reg <= low_level;
			// commands are ignored while one is still in flight
			if (wr_cmd) begin
				cmd_op_reg        <= op_type'(hwdata[1:0]);
				cmd_byte_mode_reg <= hwdata[CMD_BYTE_MODE_BIT];
				cmd_wdata_reg     <= hwdata[CMD_WDATA_LSB +: 8];
			end
			cmd_pending_reg <= wr_cmd || (cmd_pending_reg && !cyc_end);
			busy_reg        <= wr_cmd || (busy_reg && !op_done);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking chk_clk @(posedge clock); endclocking
	default disable iff (dev_rst);

	reset_hold_a: assert property (
		disable iff (rst) (reset_level && hold_count_reg == 5'(RESET_HOLD_CYCLES - 5'h01)) |=> pin_reset_reg)
		else $error("reset pin held two machine cycles did not reset");
	strobe_rate_a: assert property (
		(phase_reg == 4'h0 && cyc_reg == CYC_FETCH) |=> address_latch_strobe_out [*2]
			##1 !address_latch_strobe_out [*4] ##1 address_latch_strobe_out)
		else $error("latch strobe not at one sixth rate");
	data_skip_a: assert property (
		(cyc_reg == CYC_DATA && phase_reg == 4'h5) |=> !address_latch_strobe_out [*6])
		else $error("latch pulse not skipped in data access");
	latch_off_a: assert property (
		(!ext_exec && latch_ctrl_reg[LATCH_DISABLE_BIT] && cyc_reg == CYC_IDLE && !cyc_end)
			|=> address_latch_strobe_oe_n)
		else $error("latch strobe driven while disabled");
	exec_override_a: assert property (
		(cyc_reg == CYC_FETCH && ext_exec) |=> !address_latch_strobe_oe_n)
		else $error("disable bit honoured in external execution");
	addr_hold_a: assert property (
		($fell(address_latch_strobe_out) && !address_latch_strobe_oe_n && $past(code_read || data_cyc))
			|-> (low_port_oe_n == 8'h00 && $stable(low_port_out)))
		else $error("low address not held across strobe fall");
	fetch_release_a: assert property (
		!program_fetch_strobe_n |-> low_port_oe_n == 8'hff)
		else $error("low port driven during fetch strobe");
	fetch_twice_a: assert property (
		(cyc_reg == CYC_FETCH && phase_reg == 4'h2) |=> program_fetch_strobe_n ##1 !program_fetch_strobe_n [*3]
			##1 program_fetch_strobe_n [*3] ##1 !program_fetch_strobe_n)
		else $error("fetch strobe not twice per machine cycle");
	data_no_fetch_a: assert property (
		(cyc_reg == CYC_DATA && phase_reg == 4'h0) |=> program_fetch_strobe_n [*6] ##1 program_fetch_strobe_n [*6])
		else $error("fetch strobe active in data access");
	byte_high_a: assert property (
		(cyc_reg == CYC_DATA && cmd_byte_mode_reg && phase_reg == 4'h1) |=> high_port_out == high_latch_reg)
		else $error("high port not showing its latch");
	write_strobe_a: assert property (
		(cyc_reg == CYC_DATA && cmd_op_reg == OP_WRITE && phase_reg == 4'h3 && strobe_latch_reg[WR_STROBE_BIT])
			|=> !strobe_port_out[WR_STROBE_BIT] [*6] ##1 strobe_port_out[WR_STROBE_BIT])
		else $error("write strobe width wrong");
	open_drain_a: assert property (
		(cyc_reg == CYC_IDLE && phase_reg == 4'h4) |=> low_port_oe_n == $past(low_latch_reg))
		else $error("low port not released for ones");

	fetch_seen_c: cover property (cyc_reg == CYC_FETCH && fetch_done);
	read_seen_c: cover property (cap_out[0]);
	write_seen_c: cover property (is_write && cyc_end);
	table_seen_c: cover property (cap_out[1]);

endmodule

// ---- bench/ext_memory.sv ----
`timescale 1ns/1ps

// ****************************************
// external memory behind an address latch
// ****************************************
module ext_memory (
	// clock
	input  wire logic        clock,
	// bus pins as seen on the board
	input  wire logic        ale,
	input  wire logic        fetch_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [7:0]  addr_hi,
	input  wire logic [7:0]  bus,
	// read drive and last write seen
	output logic      [7:0]  drive,
	output logic             drive_en,
	output logic      [15:0] wr_addr,
	output logic      [7:0]  wr_data
);
	logic [7:0]  mem [65536];
	logic [15:0] addr;
	logic        ale_q  = 1'b0;
	logic        wr_q   = 1'b1;
	logic [1:0]  hold   = 2'h0;

	// every address starts with its low byte xor its high byte xor 3c
	initial begin
		for (int i = 0; i < 65536; i++)
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
	end

	// data held two clocks past the strobe, as a real part's hold time
	assign drive_en = (hold != 2'h0);

	// latch, read and write
	always @(posedge clock) begin
		ale_q <= ale;
		wr_q <= wr_n;
		if (ale_q && !ale)
			addr <= {addr_hi, bus};
		if (!fetch_n || !rd_n) begin
			hold <= 2'h2;
			drive <= mem[addr];
		end else if (hold != 2'h0)
			hold <= hold - 2'h1;
		if (!wr_q && wr_n) begin
			mem[addr] <= bus;
			wr_addr <= addr;
			wr_data <= bus;
		end
	end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("Error %s expected %h seen %h", n, e, g); end end

// ****************************************
// bench top
// ****************************************
module testbench;
	import ext_bus_pkg::*;
	logic        clock;
	logic        rst = 1'b1;
	logic        hwrite = 1'b0;
	logic        rpin = 1'b0;
	logic        sel_n = 1'b1;
	logic        lock = 1'b0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0]  htrans = 2'h0;
	logic        hreadyout, hresp, ale_o, ale_oe_n, fetch_n, m_en;
	logic [7:0]  lp_o, lp_oe_n, hp_o, hp_oe_n, sp_o, sp_oe_n, m_d, wr_data;
	logic [15:0] wr_addr;
	logic        ale_q = 1'b0;
	logic        fetch_q = 1'b1;
	int          bad_count = 0;
	int          checks = 0;
	int          n_ale, n_fetch, n_drv, n_viol;
	// pull-ups on the latch strobe and the low port when nobody drives
	wire         ale = ale_oe_n | ale_o;
	wire  [7:0]  lp = (~lp_oe_n & lp_o) | (lp_oe_n & (m_en ? m_d : 8'hff));

	external_memory_bus_interface external_memory_bus_interface_i (
		.clock(clock), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .reset_pin(rpin), .external_fetch_select_n(sel_n), .lock_bit1_programmed(lock),
		.low_port_in(lp), .low_port_out(lp_o), .low_port_oe_n(lp_oe_n), .high_port_out(hp_o),
		.high_port_oe_n(hp_oe_n), .strobe_port_out(sp_o), .strobe_port_oe_n(sp_oe_n),
		.address_latch_strobe_out(ale_o), .address_latch_strobe_oe_n(ale_oe_n),
		.program_fetch_strobe_n(fetch_n));
	ext_memory ext_memory_i (.clock(clock), .ale(ale), .fetch_n(fetch_n), .rd_n(sp_o[7]), .wr_n(sp_o[6]),
		.addr_hi(hp_o), .bus(lp), .drive(m_d), .drive_en(m_en), .wr_addr(wr_addr), .wr_data(wr_data));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// pin activity counted mid-cycle, where levels are settled
	always @(negedge clock) begin
		n_ale += int'(ale && !ale_q);
		n_fetch += int'(!fetch_n && fetch_q);
		n_drv += int'(!ale_oe_n);
		n_viol += int'((!sp_o[6] || !sp_o[7]) && (ale || !fetch_n));
		ale_q <= ale;
		fetch_q <= fetch_n;
	end

	// single word transfer; entered just after a rising edge, ready and data taken at the edge
	task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic cmd(input logic [31:0] c);
		ahb(1'b1, IDX_COMMAND, c);
		repeat (40) begin ahb(1'b0, IDX_STATUS, 0); if (rd[0] === 1'b0) break; end
	endtask

	// ten machine cycles, any alignment
	task automatic window();
		n_ale = 0;
		n_fetch = 0;
		n_drv = 0;
		repeat (120) @(posedge clock);
	endtask

	task automatic regs();
		logic [7:0] idx [7] = '{IDX_LOW_PORT, IDX_DP_LOW, IDX_DP_HIGH, IDX_LATCH_CTRL, IDX_HIGH_PORT,
			IDX_STROBE_PORT, 8'h10};
		logic [7:0] rv [7] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
		foreach (idx[i]) begin ahb(1'b0, idx[i], 0); `CHK("reset value", {24'h0, rv[i]}, rd) end
		ahb(1'b1, 8'h10, 32'hff);
		ahb(1'b0, 8'h10, 0);
		`CHK("unmapped", 32'h0, rd)
		`CHK("response", 1'b0, hresp)
	endtask

	task automatic idle();
		window();
		`CHK("latch pulses", 20, n_ale)
		`CHK("fetch pulses", 0, n_fetch)
		ahb(1'b1, IDX_LOW_PORT, 32'h0f);
		repeat (2) @(negedge clock);
		`CHK("low release", 8'h0f, lp_oe_n)
		`CHK("high release", 8'hff, hp_oe_n)
		@(posedge clock);
		ahb(1'b1, IDX_LOW_PORT, 32'hff);
		ahb(1'b1, IDX_LATCH_CTRL, 32'h1);
		// the enable pin follows the control bit one clock later
		@(posedge clock);
		window();
		`CHK("latch driven", 0, n_drv)
		ahb(1'b1, IDX_LATCH_CTRL, 32'h0);
	endtask

	task automatic data();
		ahb(1'b1, IDX_DP_HIGH, 32'h12);
		ahb(1'b1, IDX_DP_LOW, 32'h34);
		n_viol = 0;
		cmd(32'h0000_a502);
		`CHK("write address", 16'h1234, wr_addr)
		`CHK("write data", 8'ha5, wr_data)
		cmd(32'h1);
		ahb(1'b0, IDX_STATUS, 0);
		`CHK("read data", 8'ha5, rd[15:8])
		ahb(1'b1, IDX_HIGH_PORT, 32'h56);
		ahb(1'b1, IDX_BYTE_INDEX, 32'h78);
		cmd(32'h0000_3c06);
		`CHK("index address", 16'h5678, wr_addr)
		ahb(1'b1, IDX_HIGH_PORT, 32'hff);
		`CHK("strobe overlap", 0, n_viol)
	endtask

	task automatic ext();
		sel_n <= 1'b0;
		repeat (48) @(posedge clock);
		window();
		`CHK("fetch pulses", 20, n_fetch)
		ahb(1'b0, IDX_STATUS, 0);
		`CHK("external mode", 1'b1, rd[1])
		ahb(1'b1, IDX_LATCH_CTRL, 32'h1);
		window();
		`CHK("latch pulses", 20, n_ale)
		ahb(1'b1, IDX_LATCH_CTRL, 32'h0);
		n_viol = 0;
		cmd(32'h1);
		ahb(1'b1, IDX_DP_LOW, 32'h78);
		ahb(1'b1, IDX_DP_HIGH, 32'h56);
		cmd(32'h3);
		ahb(1'b0, IDX_STATUS, 0);
		`CHK("table data", 8'h3c, rd[15:8])
		`CHK("strobe overlap", 0, n_viol)
		sel_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask

	// strap copied at reset must win over the live pin
	task automatic locked();
		lock <= 1'b1;
		rst <= 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		sel_n <= 1'b0;
		repeat (48) @(posedge clock);
		window();
		`CHK("locked fetches", 0, n_fetch)
		// strap back high before the lock goes, so no stray fetch cycle starts
		sel_n <= 1'b1;
		repeat (8) @(posedge clock);
		lock <= 1'b0;
	endtask

	// short pin pulse is ignored, two machine cycles reset
	task automatic pin_reset(input int len, input logic [7:0] exp);
		ahb(1'b1, IDX_DP_LOW, 32'h34);
		rpin <= 1'b1;
		repeat (len) @(posedge clock);
		rpin <= 1'b0;
		repeat (12) @(posedge clock);
		ahb(1'b0, IDX_DP_LOW, 0);
		`CHK("pin reset", {24'h0, exp}, rd)
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		regs();
		idle();
		data();
		ext();
		locked();
		pin_reset(12, 8'h34);
		pin_reset(40, 8'h00);
		end_sim();
	end

	// hang guard, far beyond the thousand or so clocks the run needs
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		end_sim();
	end
endmodule
